// ==== logic/tam_pkg.sv ====
// Shared constants for the receive alarm and error monitor of one framer port.
// Assumes an 8-bit register port and a 50 MHz system clock.
package tam_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam logic [11:0] PORT_STRIDE = 12'h200;
    // Register offsets within one port.
    localparam logic [8:0] OFF_ALARM_CTRL = 9'h014;
    localparam logic [8:0] OFF_MODE       = 9'h015;
    localparam logic [8:0] OFF_CODE_CTRL  = 9'h016;
    localparam logic [8:0] OFF_CNT_CFG    = 9'h017;
    localparam logic [8:0] OFF_LATCHED    = 9'h018;
    localparam logic [8:0] OFF_REALTIME   = 9'h019;
    localparam logic [8:0] OFF_MW_EN0     = 9'h01a;
    localparam logic [8:0] OFF_LCV_MSB    = 9'h01d;
    localparam logic [8:0] OFF_LCV_LSB    = 9'h01e;
    localparam logic [8:0] OFF_PCV_MSB    = 9'h01f;
    localparam logic [8:0] OFF_PCV_LSB    = 9'h020;
    localparam logic [7:0] RST_REG = 8'h00;
    // Field positions.
    localparam int ALM_J1 = 0, ALM_INTEG = 1;
    localparam int MD_E1 = 0, MD_ZSUB = 1, MD_ESF = 2, MD_CRC4 = 3, MD_AUTO_BLUE_ENABLE = 4, MD_ARA = 5;
    localparam int CC_VSEL = 0, CC_FS = 2, CC_UPD = 3, CC_SHARED = 5;
    localparam int LT_BLUE_CI = 0, LT_YEL_CI = 1;
    // Counter update sources.
    localparam logic [1:0] UPD_SEC = 2'h0, UPD_FAST = 2'h1, UPD_MAN = 2'h2;
    // Timing.
    localparam int T_SEC_MS = 1000, T_T1_US = 42000, T_E1_US = 62500, T_CRC4_MS = 128;
    localparam int SEC_CYC  = CLK_HZ / 1000 * T_SEC_MS;
    localparam int T1_CYC   = CLK_HZ / 1_000_000 * T_T1_US;
    localparam int E1_CYC   = CLK_HZ / 1_000_000 * T_E1_US;
    localparam int CRC4_CYC = CLK_HZ / 1000 * T_CRC4_MS;
    // Signature zero spacing: bits 3088, 3474, 5790 of 6176.
    localparam logic [12:0] GAP1 = 13'h0182, GAP2 = 13'h090c, GAP3 = 13'h0d92;
    localparam logic [15:0] RAI_CI_CODE = 16'h3eff;
    localparam logic [4:0] ZRUN_AMI = 5'h10, ZRUN_SUB = 5'h08;
    localparam logic [4:0] LAST_CH = 5'h17;
    localparam logic [63:0] MW_PAT = 64'h1e0b0b1e9e8b8b9e;
    typedef enum logic [3:0] {
        TAM_SIG_IDLE = 4'b0001, TAM_SIG_G1 = 4'b0010,
        TAM_SIG_G2 = 4'b0100, TAM_SIG_G3 = 4'b1000
    } tam_sig_t;
endpackage : tam_pkg

// ==== logic/tam_monitor.sv ====
// Receive alarm handling and performance counters for one framer port.
// Assumes decoded line events, byte stream and alarm levels arrive synchronous to clk_sys.
// What this block does
// - alarm control holds J1 select, integration enable
// - port map repeats every 200h per port
// - E1 auto AIS on LOF, AIS, carrier loss
// - E1 auto RAI adds CRC-4 128ms timeout
// - recognise the 1.26 s AIS-CI pattern
// - signature zeros at 3088,3474,5790, with blue
// - AIS-CI flag latched, sets again every period
// - RAI-CI flag on code with yellow
// - RAI-CI integration from code filter bits
// - RAI-CI latched, re-sets while present
// - milliwatt pattern replaces enabled channels
// - counter update second, 42ms, 62.5ms, manual
// - error counters saturate, never roll over
// - shared one-second or manual update input
// - BPV same polarity, codewords excluded
// - E1 select counts BPVs or CVs
// - T1 excessive zeros 16 or 8 counted
// - line counter always counts, saturates 65535
// - T1 path counts CRC-6 or Ft/Fs
// - E1 path counts CRC-4, 16-bit split
// - latched bits set on every detection, host clears
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module tam_monitor #(
    parameter int PORT_NUM = 1,
    parameter int SEC_CYCLES = tam_pkg::SEC_CYC,
    parameter int T1_CYCLES = tam_pkg::T1_CYC,
    parameter int E1_CYCLES = tam_pkg::E1_CYC,
    parameter int CRC4_CYCLES = tam_pkg::CRC4_CYC
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Register port.
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata_q,
    // Receive line events, one per recovered bit.
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_mark,
    input  wire logic        rx_pol,
    input  wire logic        rx_codeword,
    // Framer error pulses and real-time alarms.
    input  wire logic        crc_err,
    input  wire logic        ft_err,
    input  wire logic        fs_err,
    input  wire logic        frame_sync_lost,
    input  wire logic        crc4_sync_lost,
    input  wire logic        blue_alarm,
    input  wire logic        carrier_loss,
    input  wire logic        yellow_alarm,
    // Received data-link code words.
    input  wire logic        boc_valid,
    input  wire logic [15:0] boc_word,
    // Receive bytes toward the backplane.
    input  wire logic        rx_byte_valid,
    input  wire logic [4:0]  rx_chan,
    input  wire logic [7:0]  rx_byte,
    output logic             bp_valid_q,
    output logic      [7:0]  bp_byte_q,
    // Counter update sources.
    input  wire logic        shared_sec_tick,
    input  wire logic        manual_update,
    output logic             sec_tick_q,
    output logic             timer_tick_q,
    // Alarm outputs.
    output logic             tx_force_ais_q,
    output logic             tx_force_rai_q,
    output logic             yellow_j1_select_q,
    output logic             yellow_integ_en_q
);
    import tam_pkg::*;

    logic [7:0] alarm_q, mode_q, code_q, cfg_q;
    logic [1:0] latched_q;
    logic [23:0] mw_en_q;
    logic [15:0] lcv_acc_q, pcv_acc_q, lcv_q, pcv_q;

    // Address decode: each port answers in its own 200h window.
    localparam logic [2:0] PORT_SEL = 3'(PORT_NUM - 1);
    wire        hit    = reg_addr[11:9] == PORT_SEL;
    wire [8:0]  off    = reg_addr[8:0];
    wire        wr_hit = reg_wr & hit;
    wire        e1     = mode_q[MD_E1];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alarm_q <= RST_REG;
            mode_q  <= RST_REG;
            code_q  <= RST_REG;
            cfg_q   <= RST_REG;
        end else if (wr_hit) begin
            if (off == OFF_ALARM_CTRL) alarm_q <= reg_wdata;
            if (off == OFF_MODE) mode_q <= reg_wdata;
            if (off == OFF_CODE_CTRL) code_q <= reg_wdata;
            if (off == OFF_CNT_CFG) cfg_q <= reg_wdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_mw
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) mw_en_q[g*8 +: 8] <= RST_REG;
                else if (wr_hit && off == OFF_MW_EN0 + 9'(g)) mw_en_q[g*8 +: 8] <= reg_wdata;
            end
        end
    endgenerate

    // Read mux; the answer stands in the cycle after the strobe only.
    wire [7:0] rt_stat = {3'h0, yellow_alarm, blue_alarm, carrier_loss, crc4_sync_lost, frame_sync_lost};
    wire [7:0] rd_mux =
        !hit                     ? 8'h00 :
        off == OFF_ALARM_CTRL    ? {6'h00, alarm_q[1:0]} :
        off == OFF_MODE          ? mode_q :
        off == OFF_CODE_CTRL     ? code_q :
        off == OFF_CNT_CFG       ? cfg_q :
        off == OFF_LATCHED       ? {6'h00, latched_q} :
        off == OFF_REALTIME      ? rt_stat :
        off == OFF_MW_EN0        ? mw_en_q[7:0] :
        off == OFF_MW_EN0 + 9'h1 ? mw_en_q[15:8] :
        off == OFF_MW_EN0 + 9'h2 ? mw_en_q[23:16] :
        off == OFF_LCV_MSB       ? lcv_q[15:8] :
        off == OFF_LCV_LSB       ? lcv_q[7:0] :
        off == OFF_PCV_MSB       ? pcv_q[15:8] :
        off == OFF_PCV_LSB       ? pcv_q[7:0] : 8'h00;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) reg_rdata_q <= 8'h00;
        else reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
    end

    // Automatic E1 alarms. Both enables at once is illegal; AIS then wins.
    logic [31:0] crc4_cnt_q;
    logic        crc4_to_q;
    // The wait timer restarts whenever FAS sync drops, so each reacquisition gets a full window.
    wire crc4_wait = e1 & mode_q[MD_CRC4] & ~frame_sync_lost & crc4_sync_lost;
    wire base_alm  = frame_sync_lost | blue_alarm | carrier_loss;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            crc4_cnt_q     <= '0;
            crc4_to_q      <= 1'b0;
            tx_force_ais_q <= 1'b0;
            tx_force_rai_q <= 1'b0;
        end else begin
            crc4_cnt_q     <= crc4_wait && !crc4_to_q ? crc4_cnt_q + 32'h1 : (crc4_wait ? crc4_cnt_q : '0);
            crc4_to_q      <= crc4_wait && (crc4_to_q || crc4_cnt_q == 32'(CRC4_CYCLES - 1));
            tx_force_ais_q <= e1 & mode_q[MD_AUTO_BLUE_ENABLE] & base_alm;
            tx_force_rai_q <= e1 & mode_q[MD_ARA] & ~mode_q[MD_AUTO_BLUE_ENABLE] & (base_alm | crc4_to_q);
        end
    end

    // Signature matcher: zero-to-zero spacing must walk the three gaps in order.
    tam_sig_t sig_q, sig_d;
    logic [12:0] gap_q;
    wire zero_bit = rx_bit_valid & ~rx_mark;
    always_comb begin
        sig_d = sig_q;
        if (zero_bit) begin
            case (sig_q)
                TAM_SIG_G1: sig_d = gap_q == GAP1 ? TAM_SIG_G2 : TAM_SIG_G1;
                TAM_SIG_G2: sig_d = gap_q == GAP2 ? TAM_SIG_G3 : TAM_SIG_G1;
                TAM_SIG_G3: sig_d = TAM_SIG_G1;
                default:    sig_d = TAM_SIG_G1;
            endcase
        end
    end
    wire sig_seen = zero_bit & (sig_q == TAM_SIG_G3) & (gap_q == GAP3);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sig_q <= TAM_SIG_IDLE;
            gap_q <= 13'h0;
        end else begin
            sig_q <= sig_d;
            if (zero_bit) gap_q <= 13'h1;
            else if (rx_bit_valid && gap_q != 13'h1fff) gap_q <= gap_q + 13'h1;
        end
    end

    // Code-word filter: 1, 3, 5 or 7 matching words in a row.
    logic [2:0] boc_run_q;
    wire [2:0] boc_need = {code_q[1:0], 1'b1};
    wire boc_match = boc_valid & (boc_word == RAI_CI_CODE);
    // Compare against the need minus one, so a run parked at seven cannot wrap past the limit.
    wire rai_ci_hit = boc_match & (boc_run_q >= boc_need - 3'h1) & yellow_alarm;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) boc_run_q <= 3'h0;
        else if (rai_ci_hit || (boc_valid && !boc_match)) boc_run_q <= 3'h0;
        else if (boc_match && boc_run_q != 3'h7) boc_run_q <= boc_run_q + 3'h1;
    end

    // Latched flags: write one to clear, a set in the same cycle wins.
    wire [1:0] lat_set = {rai_ci_hit, sig_seen & blue_alarm};
    wire [1:0] lat_clr = (wr_hit && off == OFF_LATCHED) ? reg_wdata[1:0] : 2'h0;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) latched_q <= 2'h0;
        else latched_q <= (latched_q & ~lat_clr) | lat_set;
    end

    // Milliwatt substitution; the pattern index steps once per frame.
    logic [2:0] mw_idx_q;
    wire [7:0] mw_byte = MW_PAT[8'(7 - mw_idx_q) * 8 +: 8];
    wire mw_on = rx_chan <= LAST_CH && mw_en_q[rx_chan];
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mw_idx_q   <= 3'h0;
            bp_valid_q <= 1'b0;
            bp_byte_q  <= 8'h00;
        end else begin
            bp_valid_q <= rx_byte_valid;
            if (rx_byte_valid) bp_byte_q <= mw_on ? mw_byte : rx_byte;
            if (rx_byte_valid && rx_chan == LAST_CH) mw_idx_q <= mw_idx_q + 3'h1;
        end
    end

    // Update timers.
    logic [31:0] sec_cnt_q, fast_cnt_q;
    wire [31:0] fast_top = e1 ? 32'(E1_CYCLES - 1) : 32'(T1_CYCLES - 1);
    wire sec_end  = sec_cnt_q == 32'(SEC_CYCLES - 1);
    wire fast_end = fast_cnt_q >= fast_top;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sec_cnt_q  <= '0;
            fast_cnt_q <= '0;
        end else begin
            sec_cnt_q  <= sec_end ? '0 : sec_cnt_q + 32'h1;
            fast_cnt_q <= fast_end ? '0 : fast_cnt_q + 32'h1;
        end
    end
    wire [1:0] upd_sel = cfg_q[CC_UPD +: 2];
    wire sec_src = cfg_q[CC_SHARED] ? shared_sec_tick : sec_end;
    wire auto_upd = (upd_sel == UPD_SEC) ? sec_src : (upd_sel == UPD_FAST) ? fast_end : 1'b0;
    wire update = auto_upd | (upd_sel == UPD_MAN && manual_update);

    // Line violation detection.
    logic last_pol_q, bpv_pol_q, bpv_seen_q;
    logic [4:0] zrun_q;
    wire mark_ev = rx_bit_valid & rx_mark;
    wire bpv = mark_ev & (rx_pol == last_pol_q) & ~(mode_q[MD_ZSUB] & rx_codeword);
    wire cv  = bpv & bpv_seen_q & (rx_pol == bpv_pol_q);
    wire [4:0] zlim = mode_q[MD_ZSUB] ? ZRUN_SUB : ZRUN_AMI;
    wire zrun_hit = zero_bit & (zrun_q + 5'h1 == zlim);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            last_pol_q <= 1'b0;
            bpv_pol_q  <= 1'b0;
            bpv_seen_q <= 1'b0;
            zrun_q     <= 5'h0;
        end else begin
            if (mark_ev) last_pol_q <= rx_pol;
            if (bpv) bpv_pol_q <= rx_pol;
            if (bpv) bpv_seen_q <= 1'b1;
            if (mark_ev || zrun_hit) zrun_q <= 5'h0;
            else if (zero_bit) zrun_q <= zrun_q + 5'h1;
        end
    end
    wire lcv_inc = e1 ? (cfg_q[CC_VSEL] ? cv : bpv)
                      : (bpv | (cfg_q[CC_VSEL] & zrun_hit));
    wire t1_pv = mode_q[MD_ESF] ? crc_err : (ft_err | (cfg_q[CC_FS] & fs_err));
    wire pcv_inc = e1 ? (crc_err & ~frame_sync_lost & ~crc4_sync_lost)
                      : (t1_pv & ~frame_sync_lost);

    // Accumulate, then hand over to the readable copy on each update.
    wire [15:0] lcv_sum = lcv_acc_q + 16'(lcv_inc && lcv_acc_q != 16'hffff);
    wire [15:0] pcv_sum = pcv_acc_q + 16'(pcv_inc && pcv_acc_q != 16'hffff);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lcv_acc_q <= '0;
            pcv_acc_q <= '0;
            lcv_q     <= '0;
            pcv_q     <= '0;
        end else if (update) begin
            lcv_q     <= lcv_sum;
            pcv_q     <= pcv_sum;
            lcv_acc_q <= '0;
            pcv_acc_q <= '0;
        end else begin
            lcv_acc_q <= lcv_sum;
            pcv_acc_q <= pcv_sum;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sec_tick_q         <= 1'b0;
            timer_tick_q       <= 1'b0;
            yellow_j1_select_q <= 1'b0;
            yellow_integ_en_q  <= 1'b0;
        end else begin
            sec_tick_q         <= sec_end;
            timer_tick_q       <= auto_upd;
            yellow_j1_select_q <= alarm_q[ALM_J1];
            yellow_integ_en_q  <= alarm_q[ALM_INTEG];
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    lcv_sat_a: assert property (lcv_acc_q == 16'hffff && !update |=> lcv_acc_q == 16'hffff)
        else $error("line accumulator rolled over");
    upd_xfer_a: assert property (update |=> lcv_q == $past(lcv_sum) && pcv_acc_q == 16'h0)
        else $error("update did not transfer counts");
    pcv_lof_a: assert property (frame_sync_lost && !update |=> pcv_acc_q == $past(pcv_acc_q))
        else $error("path counter moved during frame loss");
    ais_force_a: assert property (e1 && mode_q[MD_AUTO_BLUE_ENABLE] && carrier_loss |=> tx_force_ais_q)
        else $error("auto AIS missing");
    rai_force_a: assert property (e1 && mode_q[MD_ARA] && !mode_q[MD_AUTO_BLUE_ENABLE] && crc4_to_q |=> tx_force_rai_q)
        else $error("auto RAI missing");
    ci_set_a: assert property (sig_seen && blue_alarm |=> latched_q[LT_BLUE_CI])
        else $error("AIS-CI flag not set");
    ci_noblue_a: assert property (!latched_q[LT_BLUE_CI] && !(sig_seen && blue_alarm) |=> !latched_q[LT_BLUE_CI])
        else $error("AIS-CI flag set without cause");
    yel_ci_a: assert property (rai_ci_hit |=> latched_q[LT_YEL_CI])
        else $error("RAI-CI flag not set");
    clr_a: assert property (wr_hit && off == OFF_LATCHED && reg_wdata[0] && !lat_set[0] |=> !latched_q[0])
        else $error("latched flag not cleared");
    mw_sub_a: assert property (rx_byte_valid && mw_on |=> bp_byte_q == $past(mw_byte))
        else $error("milliwatt byte missing");
    mw_pass_a: assert property (rx_byte_valid && !mw_on |=> bp_byte_q == $past(rx_byte))
        else $error("pass-through byte changed");
    rd_data_a: assert property (reg_rd |=> reg_rdata_q == $past(rd_mux))
        else $error("read data wrong");
    lcv_cnt_a: assert property (lcv_inc && lcv_acc_q != 16'hffff && !update |=> lcv_acc_q == $past(lcv_acc_q) + 16'h1)
        else $error("line violation not counted");
    pcv_crc4_a: assert property (e1 && crc4_sync_lost && !update |=> pcv_acc_q == $past(pcv_acc_q))
        else $error("path counter moved during CRC-4 loss");

    ci_seen_c: cover property (sig_seen && blue_alarm);
    rai_ci_c: cover property (rai_ci_hit);
    lcv_upd_c: cover property (update && lcv_acc_q != 16'h0);
    zrun_c: cover property (zrun_hit && cfg_q[CC_VSEL] && !e1);
    crc4_to_c: cover property (crc4_to_q && tx_force_rai_q);
endmodule : tam_monitor

// ==== tb/tam_line_model.sv ====
// Stand-in for the line interface: replays a loaded mark pattern as recovered bits.
// Assumes the bench loads marks, polarities and length, then pulses go for one clock.
`timescale 1ns/1ps
module tam_line_model (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Pattern request, bit 0 goes first.
    input  wire logic        go,
    input  wire logic [15:0] marks,
    input  wire logic [15:0] pols,
    input  wire logic [4:0]  len,
    output logic             busy,
    // Recovered bit events toward the monitor.
    output logic             rx_bit_valid,
    output logic             rx_mark,
    output logic             rx_pol
);
    logic [4:0] idx_q;
    logic       gap_q;
    // Bits come every other clock, as a recovered line clock slower than clk_sys would.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            idx_q <= 5'h00;
            gap_q <= 1'b0;
            rx_bit_valid <= 1'b0;
            rx_mark <= 1'b0;
            rx_pol <= 1'b0;
        end else if (go) begin
            busy <= 1'b1;
            idx_q <= 5'h00;
            gap_q <= 1'b0;
        end else if (busy && !gap_q) begin
            rx_bit_valid <= 1'b1;
            rx_mark <= marks[idx_q[3:0]];
            rx_pol <= pols[idx_q[3:0]];
            idx_q <= idx_q + 5'h01;
            gap_q <= 1'b1;
            busy <= (idx_q + 5'h01) != len;
        end else begin
            // Between bits the data lines flip so a stale value is never mistaken for a bit.
            rx_bit_valid <= 1'b0;
            rx_mark <= ~rx_mark;
            rx_pol <= ~rx_pol;
            gap_q <= 1'b0;
        end
    end
endmodule : tam_line_model

// ==== tb/tam_monitor_tb_top.sv ====
// Self-checking bench for the receive alarm and error monitor of port 1.
// Assumes the line model drives recovered bits while the bench plays host and framer.
`timescale 1ns/1ps
module tam_monitor_tb_top;
    import tam_pkg::*;
    logic        clk_sys, arst_n, reg_wr, reg_rd, rx_codeword, lm_go, lm_busy;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata_q, rx_byte, bp_byte_q;
    logic        crc_err, ft_err, fs_err, frame_sync_lost, crc4_sync_lost;
    logic        blue_alarm, carrier_loss, yellow_alarm, boc_valid, rx_byte_valid;
    logic [15:0] boc_word, lm_marks, lm_pols;
    logic [4:0]  rx_chan, lm_len;
    logic        bp_valid_q, shared_sec_tick, manual_update, timer_tick_q, sec_tick_q;
    logic        tx_force_ais_q, tx_force_rai_q, j1_q, integ_q;
    logic        rx_bit_valid, rx_mark, rx_pol;
    int          error_cnt, compares;

    tam_monitor #(.PORT_NUM(1), .SEC_CYCLES(100), .T1_CYCLES(40), .E1_CYCLES(60), .CRC4_CYCLES(30)) u_dut (
        .clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .rx_bit_valid, .rx_mark, .rx_pol, .rx_codeword, .crc_err, .ft_err, .fs_err,
        .frame_sync_lost, .crc4_sync_lost, .blue_alarm, .carrier_loss, .yellow_alarm,
        .boc_valid, .boc_word, .rx_byte_valid, .rx_chan, .rx_byte, .bp_valid_q, .bp_byte_q,
        .shared_sec_tick, .manual_update, .sec_tick_q, .timer_tick_q, .tx_force_ais_q,
        .tx_force_rai_q, .yellow_j1_select_q(j1_q), .yellow_integ_en_q(integ_q));
    tam_line_model u_line (.clk_sys, .arst_n, .go(lm_go), .marks(lm_marks), .pols(lm_pols),
        .len(lm_len), .busy(lm_busy), .rx_bit_valid, .rx_mark, .rx_pol);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Shared one-second stand-in from port 1, shortened to 70 clocks.
    initial begin
        shared_sec_tick = 1'b0;
        forever begin
            repeat (69) @(posedge clk_sys);
            shared_sec_tick <= 1'b1;
            @(posedge clk_sys);
            shared_sec_tick <= 1'b0;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata_q}, {8'h00, e});
    endtask : rd_chk
    task automatic rd16(input logic [11:0] a, input logic [15:0] e);
        rd_chk(a, e[15:8]);
        rd_chk(a + 12'h001, e[7:0]);
    endtask : rd16
    // One-clock pulse: 0 crc, 1 ft, 2 fs, 3 manual update, 4 code word.
    task automatic ev(input int k);
        @(posedge clk_sys);
        {crc_err, ft_err, fs_err, manual_update, boc_valid} <= 5'h10 >> k;
        @(posedge clk_sys);
        {crc_err, ft_err, fs_err, manual_update, boc_valid} <= 5'h00;
    endtask : ev
    task automatic send(input logic [15:0] mk, input logic [15:0] pl, input logic [4:0] n);
        int i;
        @(posedge clk_sys);
        lm_marks <= mk;
        lm_pols <= pl;
        lm_len <= n;
        lm_go <= 1'b1;
        @(posedge clk_sys);
        lm_go <= 1'b0;
        #1;
        for (i = 0; i < 64 && lm_busy !== 1'b0; i++) @(posedge clk_sys) #1;
        repeat (3) @(posedge clk_sys);
    endtask : send

    task automatic t_regs();
        rd_chk(12'h014, 8'h00);
        wr(12'h014, 8'h03);
        rd_chk(12'h014, 8'h03);
        chk({14'h0000, j1_q, integ_q}, 16'h0003);
        wr(12'h214, 8'h00);
        rd_chk(12'h214, 8'h00);
        rd_chk(12'h014, 8'h03);
        rd_chk(12'h1ff, 8'h00);
        blue_alarm <= 1'b1;
        wr(12'h019, 8'h00);
        rd_chk(12'h019, 8'h08);
        blue_alarm <= 1'b0;
    endtask : t_regs
    task automatic t_auto();
        int k;
        for (k = 0; k < 6; k++) begin
            // Only one automatic alarm is ever enabled at a time.
            if (k % 3 == 0) wr(12'h015, (k < 3) ? 8'h11 : 8'h21);
            {carrier_loss, blue_alarm, frame_sync_lost} <= 3'h1 << (k % 3);
            repeat (4) @(posedge clk_sys);
            #1 chk({14'h0000, tx_force_ais_q, tx_force_rai_q}, (k < 3) ? 16'h0002 : 16'h0001);
            {carrier_loss, blue_alarm, frame_sync_lost} <= 3'h0;
            repeat (4) @(posedge clk_sys);
            #1 chk({14'h0000, tx_force_ais_q, tx_force_rai_q}, 16'h0000);
        end
        wr(12'h015, 8'h29);
        {crc4_sync_lost, frame_sync_lost} <= 2'b11;
        repeat (4) @(posedge clk_sys);
        frame_sync_lost <= 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 chk({15'h0000, tx_force_rai_q}, 16'h0000);
        repeat (30) @(posedge clk_sys);
        #1 chk({15'h0000, tx_force_rai_q}, 16'h0001);
        crc4_sync_lost <= 1'b0;
    endtask : t_auto
    task automatic t_mw();
        int f;
        int c;
        logic [7:0] e;
        wr(12'h01a, 8'h08);
        wr(12'h01c, 8'h80);
        for (f = 0; f < 8; f++) begin
            for (c = 0; c < 24; c++) begin
                e = (c == 3 || c == 23) ? MW_PAT[63 - 8 * f -: 8] : 8'h55;
                @(posedge clk_sys);
                rx_chan <= 5'(c);
                rx_byte <= 8'h55;
                rx_byte_valid <= 1'b1;
                @(posedge clk_sys);
                rx_byte_valid <= 1'b0;
                #1 chk({7'h00, bp_valid_q, bp_byte_q}, {8'h01, e});
            end
        end
    endtask : t_mw
    task automatic lcv_case(input logic [7:0] md, input logic [7:0] cf, input logic [15:0] mk,
            input logic [15:0] pl, input logic [4:0] n, input logic [15:0] e);
        wr(12'h015, md);
        wr(12'h017, cf);
        send(16'h0003, 16'h0003, 5'h02);
        ev(3);
        send(mk, pl, n);
        ev(3);
        rd16(12'h01d, e);
    endtask : lcv_case
    task automatic pcv_case(input logic [7:0] md, input logic [7:0] cf, input logic [1:0] ls,
            input logic [15:0] e);
        int i;
        wr(12'h015, md);
        wr(12'h017, cf);
        ev(3);
        for (i = 0; i < 3; i++) begin
            // The last round runs with sync lost and must not count.
            {crc4_sync_lost, frame_sync_lost} <= (i == 2) ? ls : 2'b00;
            ev(0);
            ev(1);
            ev(2);
        end
        {crc4_sync_lost, frame_sync_lost} <= 2'b00;
        ev(3);
        rd16(12'h01f, e);
    endtask : pcv_case
    task automatic tick_case(input logic [7:0] md, input logic [7:0] cf, input logic [15:0] e);
        int i;
        int n;
        wr(12'h015, md);
        wr(12'h017, cf);
        for (i = 0; i < 300 && timer_tick_q !== 1'b1; i++) @(posedge clk_sys) #1;
        n = 0;
        do begin
            @(posedge clk_sys) #1;
            n++;
        end while (n < 300 && timer_tick_q !== 1'b1);
        chk(16'(n), e);
        if (e == 16'd100) chk({15'h0000, sec_tick_q}, 16'h0001);
    endtask : tick_case
    task automatic t_raici();
        int k;
        boc_word <= 16'h3eff;
        yellow_alarm <= 1'b1;
        wr(12'h016, 8'h01);
        for (k = 1; k <= 3; k++) begin
            ev(4);
            rd_chk(12'h018, (k == 3) ? 8'h02 : 8'h00);
        end
        wr(12'h018, 8'h02);
        rd_chk(12'h018, 8'h00);
        wr(12'h016, 8'h00);
        ev(4);
        rd_chk(12'h018, 8'h02);
        wr(12'h018, 8'h02);
        yellow_alarm <= 1'b0;
        ev(4);
        rd_chk(12'h018, 8'h00);
    endtask : t_raici

    task automatic end_sim();
        $display("error_cnt=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        error_cnt = 0;
        compares = 0;
        arst_n = 1'b0;
        {reg_wr, reg_rd, rx_codeword, crc_err, ft_err, fs_err, frame_sync_lost} = 7'h00;
        {crc4_sync_lost, blue_alarm, carrier_loss, yellow_alarm, boc_valid} = 5'h00;
        {rx_byte_valid, manual_update, lm_go} = 3'h0;
        {reg_addr, reg_wdata, rx_byte, rx_chan, lm_len} = '0;
        {boc_word, lm_marks, lm_pols} = '0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_regs();
        t_mw();
        t_auto();
        frame_sync_lost <= 1'b1;
        lcv_case(8'h00, 8'h10, 16'h000f, 16'h0000, 5'h04, 16'h0003);
        frame_sync_lost <= 1'b0;
        lcv_case(8'h00, 8'h11, 16'h0000, 16'h0000, 5'h10, 16'h0001);
        lcv_case(8'h01, 8'h10, 16'h001f, 16'h0000, 5'h05, 16'h0004);
        lcv_case(8'h01, 8'h11, 16'h001f, 16'h0000, 5'h05, 16'h0003);
        rx_codeword <= 1'b1;
        lcv_case(8'h02, 8'h10, 16'h000f, 16'h0000, 5'h04, 16'h0000);
        rx_codeword <= 1'b0;
        pcv_case(8'h00, 8'h10, 2'b01, 16'h0002);
        pcv_case(8'h00, 8'h14, 2'b01, 16'h0004);
        pcv_case(8'h04, 8'h10, 2'b01, 16'h0002);
        pcv_case(8'h01, 8'h10, 2'b10, 16'h0002);
        tick_case(8'h00, 8'h08, 16'd40);
        tick_case(8'h01, 8'h08, 16'd60);
        tick_case(8'h00, 8'h00, 16'd100);
        tick_case(8'h00, 8'h20, 16'd70);
        t_raici();
        end_sim();
    end
    // Every scenario together needs about 1400 clocks.
    initial begin
        #200us;
        error_cnt++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    end
endmodule : tam_monitor_tb_top
